// ### rtl/lmxc_pkg.sv
// Constants, register map and types for the LED matrix control register bank
package lmxc_pkg;

  // Serial port device address: upper bits arbitrary, low two bits from pins
  localparam logic [4:0] DEV_ADDR_HIGH   = 5'h0B;

  // Register offsets
  localparam logic [7:0] ADDR_RESET_CTRL = 8'h01;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h02;
  localparam logic [7:0] ADDR_OPTION     = 8'h04;
  localparam logic [7:0] ADDR_MATRIX     = 8'h05;
  localparam logic [7:0] ADDR_PWM_FIRST  = 8'h06;
  localparam logic [7:0] ADDR_PWM_LAST   = 8'h10;
  localparam logic [7:0] ADDR_MLD_FIRST  = 8'h11;
  localparam logic [7:0] ADDR_MLD_LAST   = 8'h1B;
  localparam logic [7:0] ADDR_GROUP_MODE = 8'h2A;
  localparam logic [7:0] ADDR_THRESHOLD  = 8'h2B;

  // Field positions
  localparam int RST_SOFT_BIT    = 0;
  localparam int RST_MEMCLR_BIT  = 1;
  localparam int OSC_ON_BIT      = 0;
  localparam int OPT_EXTERNAL_CLOCK_SELECT_BIT  = 0;
  localparam int OPT_CLOCK_OUT_ENABLE_BIT  = 1;
  localparam int OPT_MELODY_BIT  = 2;
  localparam int OPT_GHOST_BIT   = 3;
  localparam int MTX_ON_BIT      = 0;
  localparam int MTX_PEAK_CURRENT_SELECT_LSB    = 1;
  localparam int MTX_PEAK_CURRENT_SELECT_MSB    = 3;

  // Widths, masks and reset values
  localparam int NUM_EN_REGS     = 11;
  localparam int NUM_ROWS        = 9;
  localparam logic [7:0] POWER_MASK   = 8'h01;
  localparam logic [7:0] OPTION_MASK  = 8'h0F;
  localparam logic [7:0] MATRIX_MASK  = 8'h1F;
  localparam logic [7:0] GROUP_MASK   = 8'h0F;
  localparam logic [7:0] POWER_RESET  = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] MATRIX_RESET = 8'h1E;
  localparam logic [7:0] EN_RESET     = 8'h00;
  localparam logic [7:0] GROUP_RESET  = 8'h00;
  localparam logic [7:0] THRESHOLD_SELECT_RESET  = 8'h00;
  localparam logic [8:0] ROW_TOP_ONEHOT = 9'h100;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // Serial port states, Gray along address, pointer, write, read
  typedef enum logic [2:0] {
    LMXC_IDLE   = 3'b000,
    LMXC_ADDR   = 3'b001,
    LMXC_PTR    = 3'b011,
    LMXC_WDATA  = 3'b010,
    LMXC_RDATA  = 3'b110,
    LMXC_IGNORE = 3'b111
  } lmxc_port_state_t;

endpackage

// ### rtl/lmxc_serial_port.sv
// Two-wire serial slave: pointer, auto-increment writes and reads
`timescale 1ns/1ns
`default_nettype none
module lmxc_serial_port (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Register side
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] rd_data,
  output logic            wr_strobe,
  output logic [7:0]      reg_ptr,
  output logic [7:0]      wr_data
);

  lmxc_pkg::lmxc_port_state_t state;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic       ack_phase;
  logic [7:0] shift_in;
  logic [7:0] tx_byte;
  logic       master_ack;

  wire scl_rise  = scl_in & ~scl_q;
  wire scl_fall  = ~scl_in & scl_q;
  wire start_cnd = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cnd  = scl_in & scl_q & ~sda_q & sda_in;
  wire addr_hit  = (shift_in[7:1] == dev_addr);
  wire byte_done = ~ack_phase & (bit_cnt == lmxc_pkg::BYTE_BITS);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state      <= lmxc_pkg::LMXC_IDLE;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      bit_cnt    <= 4'h0;
      ack_phase  <= 1'b0;
      shift_in   <= 8'h00;
      tx_byte    <= 8'h00;
      master_ack <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      wr_strobe  <= 1'b0;
      reg_ptr    <= 8'h00;
      wr_data    <= 8'h00;
    end
    else if (clk_en)
    begin
      scl_q     <= scl_in;
      sda_q     <= sda_in;
      wr_strobe <= 1'b0;
      if (start_cnd)
      begin
        state     <= lmxc_pkg::LMXC_ADDR;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end
      else if (stop_cnd)
      begin
        state  <= lmxc_pkg::LMXC_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (ack_phase)
          master_ack <= ~sda_in;
        else if (bit_cnt != lmxc_pkg::BYTE_BITS)
        begin
          shift_in <= {shift_in[6:0], sda_in};
          bit_cnt  <= bit_cnt + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        if (byte_done)
        begin
          ack_phase <= 1'b1;
          case (state)
            lmxc_pkg::LMXC_ADDR:
            begin
              sda_oe <= addr_hit;
              if (!addr_hit)
                state <= lmxc_pkg::LMXC_IGNORE;
            end
            lmxc_pkg::LMXC_PTR:
            begin
              sda_oe  <= 1'b1;
              reg_ptr <= shift_in;
            end
            lmxc_pkg::LMXC_WDATA:
            begin
              sda_oe    <= 1'b1;
              wr_strobe <= 1'b1;
              wr_data   <= shift_in;
            end
            default: sda_oe <= 1'b0;
          endcase
        end
        else if (ack_phase)
        begin
          ack_phase <= 1'b0;
          bit_cnt   <= 4'h0;
          sda_oe    <= 1'b0;
          case (state)
            lmxc_pkg::LMXC_ADDR:
            begin
              if (shift_in[0])
              begin
                state   <= lmxc_pkg::LMXC_RDATA;
                tx_byte <= rd_data;
                sda_oe  <= ~rd_data[7];
                reg_ptr <= reg_ptr + 8'h01;
              end
              else
                state <= lmxc_pkg::LMXC_PTR;
            end
            lmxc_pkg::LMXC_PTR:   state <= lmxc_pkg::LMXC_WDATA;
            lmxc_pkg::LMXC_WDATA: reg_ptr <= reg_ptr + 8'h01;
            lmxc_pkg::LMXC_RDATA:
            begin
              // Master not acknowledging ends the read burst
              if (master_ack)
              begin
                tx_byte <= rd_data;
                sda_oe  <= ~rd_data[7];
                reg_ptr <= reg_ptr + 8'h01;
              end
              else
                state <= lmxc_pkg::LMXC_IGNORE;
            end
            default: state <= state;
          endcase
        end
        else if (state == lmxc_pkg::LMXC_RDATA)
        begin
          tx_byte <= {tx_byte[6:0], 1'b0};
          sda_oe  <= ~tx_byte[6];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/lmxc_melody_seq.sv
// Column-group melody sequencer, stepping rows I down to A on each beat
`timescale 1ns/1ns
`default_nettype none
module lmxc_melody_seq (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Control
  input  wire logic       run,
  input  wire logic       melody_in,
  input  wire logic [3:0] group_sel,
  // Drive
  output logic [8:0]      row_lit,
  output logic [3:0]      col_active
);

  logic melody_q;
  wire  beat = melody_in & ~melody_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      melody_q   <= 1'b0;
      row_lit    <= 9'h000;
      col_active <= 4'h0;
    end
    else if (clk_en)
    begin
      melody_q   <= melody_in;
      col_active <= run ? group_sel : 4'h0;
      if (!run)
        row_lit <= 9'h000;
      else if (row_lit == 9'h000)
        row_lit <= lmxc_pkg::ROW_TOP_ONEHOT;
      else if (beat)
        row_lit <= row_lit[0] ? lmxc_pkg::ROW_TOP_ONEHOT : (row_lit >> 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_row_wraps_top: assert property (clk_en && run && beat && row_lit[0] |=> row_lit == 9'h100)
    else $error("melody row did not wrap from A back to I");
  a_row_steps_down: assert property (clk_en && run && beat && row_lit[8] |=> row_lit == 9'h080)
    else $error("melody row did not step from I to H");
  a_group_follows: assert property (clk_en && run |=> col_active == $past(group_sel))
    else $error("column group not driven while melody runs");
  c_melody_wrap: cover property (clk_en && run && beat && row_lit[0]);

endmodule
`default_nettype wire

// ### rtl/lmxc_regs.sv
// LED matrix control register bank behind the two-wire serial port
`timescale 1ns/1ns
`default_nettype none
module lmxc_regs (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [1:0]  addr_sel,
  // Clock and melody pins
  input  wire logic        osc_clk_level,
  input  wire logic        melody_in,
  output logic             clock_out_pin,
  // Device control
  output logic             device_reset_pulse,
  output logic             intensity_memory_clear,
  output logic             osc_run,
  output logic             external_clock_select,
  output logic             ghost_suppress_en,
  output logic             melody_input_select,
  output logic [2:0]       peak_current_select,
  output logic             matrix_drive_on,
  output logic [87:0]      led_pwm_enable,
  output logic [87:0]      led_melody_enable,
  output logic [8:0]       melody_row_lit,
  output logic [3:0]       column_group_melody,
  output logic [7:0]       threshold_select,
  output logic             auto_threshold
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [3:0] en_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[3:0];
  endfunction

  logic [7:0] power_reg;
  logic [7:0] option_reg;
  logic [7:0] matrix_reg;
  logic [7:0] group_reg;
  logic [7:0] threshold_select_reg;
  logic [7:0] pwm_mem [0:lmxc_pkg::NUM_EN_REGS-1];
  logic [7:0] mld_mem [0:lmxc_pkg::NUM_EN_REGS-1];

  wire        wr_strobe;
  wire [7:0]  reg_ptr;
  wire [7:0]  wr_data;
  wire [7:0]  rd_data;
  wire [8:0]  seq_rows;
  wire [3:0]  seq_cols;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire        wr_go      = wr_strobe & clk_en;
  wire        hit_reset  = (reg_ptr == lmxc_pkg::ADDR_RESET_CTRL);
  wire        hit_power  = (reg_ptr == lmxc_pkg::ADDR_POWER_CTRL);
  wire        hit_option = (reg_ptr == lmxc_pkg::ADDR_OPTION);
  wire        hit_matrix = (reg_ptr == lmxc_pkg::ADDR_MATRIX);
  wire        hit_group  = (reg_ptr == lmxc_pkg::ADDR_GROUP_MODE);
  wire        hit_threshold_select  = (reg_ptr == lmxc_pkg::ADDR_THRESHOLD);
  wire        hit_pwm    = in_range(reg_ptr, lmxc_pkg::ADDR_PWM_FIRST, lmxc_pkg::ADDR_PWM_LAST);
  wire        hit_mld    = in_range(reg_ptr, lmxc_pkg::ADDR_MLD_FIRST, lmxc_pkg::ADDR_MLD_LAST);
  wire [3:0]  pwm_idx    = en_index(reg_ptr, lmxc_pkg::ADDR_PWM_FIRST);
  wire [3:0]  mld_idx    = en_index(reg_ptr, lmxc_pkg::ADDR_MLD_FIRST);
  wire        soft_req   = wr_go & hit_reset & wr_data[lmxc_pkg::RST_SOFT_BIT];
  wire        clr_req    = wr_go & hit_reset & wr_data[lmxc_pkg::RST_MEMCLR_BIT];
  wire        cfg_reset  = reset | device_reset_pulse;

  wire        ext_sel    = option_reg[lmxc_pkg::OPT_EXTERNAL_CLOCK_SELECT_BIT];
  wire        clock_out_enable_sel = option_reg[lmxc_pkg::OPT_CLOCK_OUT_ENABLE_BIT] & ~ext_sel;
  wire        melody_sel = option_reg[lmxc_pkg::OPT_MELODY_BIT] & ~option_reg[lmxc_pkg::OPT_CLOCK_OUT_ENABLE_BIT] & ~ext_sel;

  // Write-only and unmapped addresses read as zero
  // zero readback
  assign rd_data = hit_power  ? power_reg  :
                   hit_option ? option_reg :
                   hit_matrix ? matrix_reg :
                   hit_pwm    ? pwm_mem[pwm_idx] :
                   hit_mld    ? mld_mem[mld_idx] :
                   hit_group  ? group_reg  :
                   hit_threshold_select  ? threshold_select_reg  : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  lmxc_serial_port u_port (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .dev_addr  ({lmxc_pkg::DEV_ADDR_HIGH, addr_sel}),
    .rd_data   (rd_data),
    .wr_strobe (wr_strobe),
    .reg_ptr   (reg_ptr),
    .wr_data   (wr_data)
  );

  lmxc_melody_seq u_melody (
    .core_clk   (core_clk),
    .reset      (cfg_reset),
    .clk_en     (clk_en),
    .run        (melody_sel & (group_reg[3:0] != 4'h0)),
    .melody_in  (melody_in),
    .group_sel  (group_reg[3:0]),
    .row_lit    (seq_rows),
    .col_active (seq_cols)
  );

  assign melody_row_lit      = seq_rows;
  assign column_group_melody = seq_cols;

  ////////////////////////////////////////////////////////////////////////
  // Self-clearing reset-control pulses
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      device_reset_pulse     <= 1'b0;
      intensity_memory_clear <= 1'b0;
    end
    else if (clk_en)
    begin
      device_reset_pulse     <= soft_req;
      intensity_memory_clear <= clr_req;
    end
  end

  // Configuration registers; reserved bits masked at write
  always_ff @(posedge core_clk)
  begin
    if (cfg_reset)
    begin
      power_reg  <= lmxc_pkg::POWER_RESET;
      option_reg <= lmxc_pkg::OPTION_RESET;
      matrix_reg <= lmxc_pkg::MATRIX_RESET;
      group_reg  <= lmxc_pkg::GROUP_RESET;
      threshold_select_reg  <= lmxc_pkg::THRESHOLD_SELECT_RESET;
      for (int i = 0; i < lmxc_pkg::NUM_EN_REGS; i++)
      begin
        pwm_mem[i] <= lmxc_pkg::EN_RESET;
        mld_mem[i] <= lmxc_pkg::EN_RESET;
      end
    end
    else if (wr_go)
    begin
      if (hit_power)
        power_reg <= wr_data & lmxc_pkg::POWER_MASK;
      if (hit_option)
        option_reg <= wr_data & lmxc_pkg::OPTION_MASK;
      if (hit_matrix)
        matrix_reg <= wr_data & lmxc_pkg::MATRIX_MASK;
      if (hit_pwm)
        pwm_mem[pwm_idx] <= wr_data;
      if (hit_mld)
        mld_mem[mld_idx] <= wr_data;
      if (hit_group)
        group_reg <= wr_data & lmxc_pkg::GROUP_MASK;
      if (hit_threshold_select)
        threshold_select_reg <= wr_data;
    end
  end

  // Derived outputs, registered
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      osc_run       <= 1'b0;
      clock_out_pin <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_run       <= power_reg[lmxc_pkg::OSC_ON_BIT] | matrix_reg[lmxc_pkg::MTX_ON_BIT];
      clock_out_pin <= clock_out_enable_sel & osc_clk_level;
    end
  end

  // Mode flags registered so no output leaves through gates
  always_ff @(posedge core_clk)
  begin
    if (cfg_reset)
    begin
      melody_input_select <= 1'b0;
      auto_threshold      <= 1'b1;
    end
    else if (clk_en)
    begin
      melody_input_select <= melody_sel;
      if (wr_go && hit_threshold_select)
        auto_threshold <= (wr_data == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field outputs straight from the registers
  // external clock select
  assign external_clock_select = ext_sel;
  assign ghost_suppress_en     = option_reg[lmxc_pkg::OPT_GHOST_BIT];
  assign peak_current_select   = matrix_reg[lmxc_pkg::MTX_PEAK_CURRENT_SELECT_MSB:lmxc_pkg::MTX_PEAK_CURRENT_SELECT_LSB];
  assign matrix_drive_on       = matrix_reg[lmxc_pkg::MTX_ON_BIT];
  assign threshold_select      = threshold_select_reg;

  for (genvar g = 0; g < lmxc_pkg::NUM_EN_REGS; g++)
  begin : g_flat
    assign led_pwm_enable[g*8 +: 8]    = pwm_mem[g];
    assign led_melody_enable[g*8 +: 8] = mld_mem[g];
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_soft_reset_pulse: assert property (soft_req |=> device_reset_pulse ##1 !device_reset_pulse)
    else $error("soft reset write did not give a single pulse");
  a_memclr_pulse: assert property (clr_req |=> intensity_memory_clear)
    else $error("memory clear write did not raise the clear strobe");
  a_reset_self_clear: assert property (clk_en && !soft_req && !clr_req |=> !device_reset_pulse && !intensity_memory_clear)
    else $error("reset control bit stayed set");
  a_soft_defaults: assert property (device_reset_pulse |=> matrix_reg == 8'h1E && option_reg == 8'h00 && power_reg == 8'h00)
    else $error("soft reset did not restore defaults");
  a_osc_follows_bit: assert property (clk_en && power_reg[0] |=> osc_run)
    else $error("oscillator not running with its enable set");
  a_osc_matrix_on: assert property (clk_en && matrix_reg[0] |=> osc_run)
    else $error("oscillator not running while matrix is on");
  a_osc_off: assert property (clk_en && power_reg == 8'h00 && !matrix_reg[0] |=> !osc_run)
    else $error("oscillator running with both enables clear");
  a_ext_clock_first: assert property (clk_en && option_reg[0] |=> !clock_out_pin && !melody_input_select)
    else $error("external clock did not take priority");
  a_clock_out_enable_blocked: assert property (clk_en && !option_reg[1] |=> !clock_out_pin)
    else $error("internal clock seen on output pin while disabled");
  a_pwm_bank_write: assert property (wr_go && hit_pwm && !device_reset_pulse |=> pwm_mem[$past(pwm_idx)] == $past(wr_data))
    else $error("PWM enable write not stored");
  a_unmapped_zero: assert property (!(hit_power || hit_option || hit_matrix || hit_pwm || hit_mld || hit_group || hit_threshold_select) |-> rd_data == 8'h00)
    else $error("unmapped address did not read zero");
  a_reserved_bits: assert property (option_reg[7:4] == 4'h0 && power_reg[7:1] == 7'h00 && matrix_reg[7:5] == 3'h0)
    else $error("reserved bits are not zero");
  a_auto_threshold: assert property (clk_en && wr_go && hit_threshold_select && wr_data == 8'h00 && !device_reset_pulse |=> auto_threshold)
    else $error("zero threshold did not select automatic detection");
  a_melody_after_clock_out_enable: assert property (clk_en && option_reg[1] |=> !melody_input_select)
    else $error("melody mode not blocked by clock output");
  a_melody_needs_bit: assert property (clk_en && !option_reg[2] |=> !melody_input_select)
    else $error("melody mode active with its bit clear");

  c_soft_reset: cover property (soft_req ##2 matrix_reg == 8'h1E);
  c_melody_run: cover property (melody_input_select && column_group_melody != 4'h0);
  c_read_burst: cover property (hit_pwm && sda_oe);

endmodule
`default_nettype wire

// ### tb/lmxc_host_model.sv
// Serial host model that writes and reads the register port
`timescale 1ns/1ns
`default_nettype none
module lmxc_host_model (
  // Clock
  input  wire logic  core_clk,
  // Bus, data line open drain
  input  wire logic  sda_line,
  output logic       scl,
  output logic       sda_drv,
  // Byte read back
  output logic       rd_valid,
  output logic [7:0] rd_byte
);
  int nacks = 0;
  initial {scl, sda_drv, rd_valid, rd_byte} = 11'h600;
  task automatic hw(int n);
    repeat (3 * n) @(posedge core_clk);
  endtask
  // Start when f is one, stop otherwise
  task automatic cond(logic f);
    hw(1);
    sda_drv <= f;
    hw(1);
    scl <= 1'b1;
    hw(1);
    sda_drv <= ~f;
    hw(1);
    scl <= ~f;
  endtask
  // Data settles a phase before clock rises
  task automatic bitx(input logic b, output logic r);
    hw(1);
    sda_drv <= b;
    hw(1);
    scl <= 1'b1;
    hw(2);
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic [8:0] v;
    v = {d, 1'b1};
    for (int i = 8; i >= 0; i--)
      bitx(v[i], v[i]);
    q = v[8:1];
    ack = ~v[0];
  endtask
  task automatic xfer(input logic [6:0] dev, input logic [7:0] a, d, input logic rd);
    logic [7:0] q;
    logic       ack;
    cond(1'b1);
    byte_x({dev, 1'b0}, q, ack);
    if (ack)
      byte_x(a, q, ack);
    if (ack && rd)
      cond(1'b1);
    if (ack && rd)
      byte_x({dev, 1'b1}, q, ack);
    if (ack)
      byte_x(rd ? 8'hFF : d, q, ack);
    nacks += int'(!ack && !rd);
    rd_byte <= q;
    rd_valid <= rd;
    @(posedge core_clk);
    rd_valid <= 1'b0;
    cond(1'b0);
  endtask
endmodule
`default_nettype wire

// ### tb/lmxc_regs_tb.sv
// Self-checking bench for the LED matrix control register bank
`timescale 1ns/1ns
`default_nettype none
module lmxc_regs_tb;
  localparam logic [6:0] DEV = {lmxc_pkg::DEV_ADDR_HIGH, 2'h2};
  logic         core_clk = 1'b0, reset = 1'b1, osc = 1'b0, osc_q = 1'b0, mel = 1'b0, en = 1'b1, sda_o;
  logic         scl, sda_drv, sda_oe, rd_valid, ck_out, soft_reset_bit, mclr, osc_run, ext, ghost, mel_sel, drv_on, auto_th;
  logic [2:0]   peak;
  logic [3:0]   grp;
  logic [7:0]   rd_byte, thr, d;
  logic [8:0]   row, r;
  logic [87:0]  pwm, mld;
  logic [175:0] en_exp;
  logic [7:0]   expq[$];
  logic [7:0]   ra[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h2A, 8'h2B};
  int           seed = 32'h3692, miscompares = 0, checks_done = 0, clr_n = 0, soft_reset_bit_n = 0;
  wire          sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
  lmxc_regs dut (.core_clk(core_clk), .reset(reset), .clk_en(en), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe(sda_oe), .addr_sel(2'h2), .osc_clk_level(osc), .melody_in(mel), .clock_out_pin(ck_out),
    .device_reset_pulse(soft_reset_bit), .intensity_memory_clear(mclr), .osc_run(osc_run), .external_clock_select(ext),
    .ghost_suppress_en(ghost), .melody_input_select(mel_sel), .peak_current_select(peak), .matrix_drive_on(drv_on),
    .led_pwm_enable(pwm), .led_melody_enable(mld), .melody_row_lit(row), .column_group_melody(grp),
    .threshold_select(thr), .auto_threshold(auto_th));
  lmxc_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv),
    .rd_valid(rd_valid), .rd_byte(rd_byte));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    osc <= 1'($random(seed));
    osc_q <= osc;
    clr_n <= clr_n + int'(mclr === 1'b1);
    soft_reset_bit_n <= soft_reset_bit_n + int'(soft_reset_bit === 1'b1);
    if (rd_valid === 1'b1)
      chk(rd_byte, expq.pop_front());
  end
  task automatic chk(input logic [87:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    host.xfer(DEV, a, v, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, e);
    expq.push_back(e);
    host.xfer(DEV, a, 8'h00, 1'b1);
  endtask
  task automatic defaults;
    foreach (ra[i])
      rd(ra[i], ra[i] == 8'h05 ? 8'h1E : 8'h00);
    chk({peak, auto_th}, 4'hF);
    chk(pwm | mld, 88'h0);
  endtask
  task automatic beat;
    mel <= 1'b1;
    repeat (4) @(posedge core_clk);
    mel <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic close_out;
    $display("checks %0d bad %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    close_out;
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    defaults;
    $display("reset values done");
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h01);
    chk(osc_run, 1'b1);
    wr(8'h02, 8'h00);
    chk(osc_run, 1'b0);
    wr(8'h05, 8'hF3);
    rd(8'h05, 8'h13);
    chk({peak, drv_on, osc_run}, 5'h07);
    $display("power and matrix done");
    for (int v = 0; v < 16; v++)
    begin
      wr(8'h04, 8'(v) | 8'hF0);
      rd(8'h04, 8'(v));
      chk({ghost, mel_sel, ext}, {v[3], v[2] & !v[1] & !v[0], v[0]});
      repeat (8) @(negedge core_clk) chk(ck_out, osc_q & v[1] & !v[0]);
    end
    $display("option bits done");
    for (int k = 0; k < 22; k++)
    begin
      d = 8'($random(seed));
      en_exp[k * 8 +: 8] = d;
      wr(8'h06 + 8'(k), d);
      rd(8'h06 + 8'(k), d);
    end
    chk(pwm, en_exp[87:0]);
    chk(mld, en_exp[175:88]);
    $display("enable registers done");
    wr(8'h04, 8'h04);
    wr(8'h2A, 8'hFF);
    rd(8'h2A, 8'h0F);
    beat;
    r = row;
    for (int i = 0; i < 9; i++)
    begin
      beat;
      r = {r[0], r[8:1]};
      chk({grp, row}, {4'hF, r});
    end
    // Enable low must freeze the sequencer through a whole beat
    en <= 1'b0;
    beat;
    chk({grp, row}, {4'hF, r});
    en <= 1'b1;
    $display("melody done");
    wr(8'h2B, 8'h04);
    chk({thr, auto_th}, 9'h008);
    wr(8'h01, 8'h02);
    chk(clr_n * 4 + soft_reset_bit_n, 4);
    wr(8'h01, 8'h01);
    chk(clr_n * 4 + soft_reset_bit_n, 5);
    defaults;
    host.xfer(DEV ^ 7'h01, 8'h05, 8'h01, 1'b0);
    chk({drv_on, host.nacks}, 33'h1);
    $display("soft reset and refusal done");
    repeat (10) @(posedge core_clk);
    close_out;
  end
endmodule
`default_nettype wire
